/* File: logic/i2cs_top.sv */
// Purpose: two-wire serial port slave with start/stop detection for firmware master use
// Assumes: bus lines sampled by clk, external pull-ups, single-cycle register strobes
// Notes: slave stretches the clock line only after the ninth clock, never mid-byte
//
// Chosen here: strobed register access.
`timescale 1ns/10ps
`default_nettype none

module i2cs_top (
   // clock and reset
   input  wire logic               clk,
   input  wire logic               rst_n,
   // register port
   input  wire logic [7:0]         reg_addr,
   input  wire logic [7:0]         reg_wdata,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   output logic      [7:0]         reg_rdata,
   // bus lines, open drain
   input  wire i2cs_pkg::i2cs_line_s line_in,
   output i2cs_pkg::i2cs_line_s      line_out,
   output i2cs_pkg::i2cs_line_s      line_oe_n,
   // processor interrupt
   output logic                    irq
);

   i2cs_pkg::i2cs_state_e st_r;
   logic [2:0] scl_s_r, sda_s_r;
   logic       scl_lvl_r, sda_lvl_r;
   logic [7:0] intc_r, flags_r, pie_r, dir_r, addr_r, buf_r, sr_r, rdata_r;
   logic [3:0] mode_r, cnt_r;
   logic       smp_r, cke_r, en_r, wcol_r, ov_r, ckp_r;
   logic       bf_r, ua_r, rw_r, da_r, s_r, p_r;
   logic       is_addr_r, ten_lo_r, ten_done_r, ack_r, tx_next_r, ua_pend_r, mack_r;
   logic       scl_oe_n_r, sda_oe_n_r, irq_r;
   logic       scl_agree, sda_agree, scl_rise, scl_fall, sda_rise, sda_fall;
   logic       start_ev, stop_ev, port_on, slave_on, ten_mode, sp_mode;
   logic       byte_end, hit, take, nak_hit, miss, ack_fall, txack_fall, tx_done;
   logic       wr_buf, rd_buf, wr_addr, sda_low, scl_hold;

   // three-stage line synchronisers; first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_s_r <= 3'h7;
         sda_s_r <= 3'h7;
      end else begin
         scl_s_r <= {scl_s_r[1:0], line_in.scl};
         sda_s_r <= {sda_s_r[1:0], line_in.sda};
      end
   end

   // a change counts once stages two and three agree
   assign scl_agree = scl_s_r[1] == scl_s_r[2];
   assign sda_agree = sda_s_r[1] == sda_s_r[2];
   assign scl_rise  = scl_agree && scl_s_r[2] && !scl_lvl_r;
   assign scl_fall  = scl_agree && !scl_s_r[2] && scl_lvl_r;
   assign sda_rise  = sda_agree && sda_s_r[2] && !sda_lvl_r;
   assign sda_fall  = sda_agree && !sda_s_r[2] && sda_lvl_r;

   // filtered line levels
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_lvl_r <= 1'b1;
         sda_lvl_r <= 1'b1;
      end else begin
         scl_lvl_r <= scl_agree ? scl_s_r[2] : scl_lvl_r;
         sda_lvl_r <= sda_agree ? sda_s_r[2] : sda_lvl_r;
      end
   end

   // mode decode and bus conditions
   assign port_on  = en_r && i2cs_pkg::i2cs_mode_ok(mode_r);
   assign slave_on = en_r && i2cs_pkg::i2cs_mode_slave(mode_r);
   assign ten_mode = i2cs_pkg::i2cs_mode_ten(mode_r);
   assign sp_mode  = i2cs_pkg::i2cs_mode_sp(mode_r);
   assign start_ev = port_on && sda_fall && scl_lvl_r;
   assign stop_ev  = port_on && sda_rise && scl_lvl_r;

   // register strobes with side effects
   assign wr_buf  = reg_wr && (reg_addr == i2cs_pkg::OFS_SER_BUF);
   assign rd_buf  = reg_rd && (reg_addr == i2cs_pkg::OFS_SER_BUF);
   assign wr_addr = reg_wr && (reg_addr == i2cs_pkg::OFS_SLV_ADDR);

   // address compare at the end of the eighth clock
   always_comb begin
      logic hit7;
      hit7     = 1'b0;
      byte_end = (st_r == i2cs_pkg::ST_RX) && scl_fall && (cnt_r == i2cs_pkg::BYTE_BITS);
      hit7     = (sr_r[i2cs_pkg::ADR_MSB:i2cs_pkg::ADR_LSB] == addr_r[i2cs_pkg::ADR_MSB:i2cs_pkg::ADR_LSB]) &&
                 (sr_r[i2cs_pkg::ADR_MSB:i2cs_pkg::ADR_LSB] != i2cs_pkg::GEN_CALL);
      if (!is_addr_r) begin
         hit = 1'b1;
      end else if (ten_mode && ten_lo_r) begin
         hit = sr_r == addr_r;
      end else if (ten_mode) begin
         hit = hit7 && (sr_r[i2cs_pkg::ADR_MSB:i2cs_pkg::TEN_LSB] == i2cs_pkg::TEN_PREFIX) &&
               (!sr_r[i2cs_pkg::RW_BIT] || ten_done_r);
      end else begin
         hit = hit7;
      end
      take    = byte_end && hit && !bf_r && !ov_r;
      nak_hit = byte_end && hit && (bf_r || ov_r);
      miss    = byte_end && !hit;
   end

   assign ack_fall   = (st_r == i2cs_pkg::ST_ACK) && scl_fall;
   assign txack_fall = (st_r == i2cs_pkg::ST_TXACK) && scl_fall;
   assign tx_done    = (st_r == i2cs_pkg::ST_TX) && scl_fall && (cnt_r == i2cs_pkg::LAST_TX_FALL);

   // slave sequencer, shift register and bit counter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r       <= i2cs_pkg::ST_IDLE;
         sr_r       <= i2cs_pkg::RST_ZERO;
         cnt_r      <= i2cs_pkg::CNT_ZERO;
         is_addr_r  <= 1'b0;
         ten_lo_r   <= 1'b0;
         ten_done_r <= 1'b0;
         ack_r      <= 1'b0;
         tx_next_r  <= 1'b0;
         ua_pend_r  <= 1'b0;
         mack_r     <= 1'b0;
      end else if (!slave_on) begin
         st_r       <= i2cs_pkg::ST_IDLE;
         ten_lo_r   <= 1'b0;
         ten_done_r <= 1'b0;
      end else if (start_ev) begin
         st_r      <= i2cs_pkg::ST_RX;
         cnt_r     <= i2cs_pkg::CNT_ZERO;
         is_addr_r <= 1'b1;
         ten_lo_r  <= 1'b0;
      end else if (stop_ev) begin
         st_r       <= i2cs_pkg::ST_IDLE;
         ten_done_r <= 1'b0;
      end else begin
         case (st_r)
            i2cs_pkg::ST_RX: begin
               if (scl_rise && (cnt_r != i2cs_pkg::BYTE_BITS)) begin
                  sr_r  <= {sr_r[6:0], sda_lvl_r};
                  cnt_r <= cnt_r + i2cs_pkg::CNT_ONE;
               end else if (miss) begin
                  st_r <= i2cs_pkg::ST_IDLE;
               end else if (byte_end) begin
                  st_r      <= i2cs_pkg::ST_ACK;
                  cnt_r     <= i2cs_pkg::CNT_ZERO;
                  ack_r     <= take;
                  ua_pend_r <= take && is_addr_r && ten_mode && (ten_lo_r || !sr_r[i2cs_pkg::RW_BIT]);
                  tx_next_r <= take && is_addr_r && !ten_lo_r && sr_r[i2cs_pkg::RW_BIT];
                  is_addr_r <= take && is_addr_r && ten_mode && !ten_lo_r && !sr_r[i2cs_pkg::RW_BIT];
                  ten_lo_r  <= take && is_addr_r && ten_mode && !ten_lo_r && !sr_r[i2cs_pkg::RW_BIT];
                  if (take && is_addr_r && ten_mode && ten_lo_r) begin
                     ten_done_r <= 1'b1;
                  end
               end
            end
            i2cs_pkg::ST_ACK: begin
               if (scl_fall) begin
                  st_r <= (tx_next_r && ack_r) ? i2cs_pkg::ST_TXW : i2cs_pkg::ST_RX;
               end
            end
            i2cs_pkg::ST_TXW: begin
               if (wr_buf) begin
                  sr_r <= reg_wdata;
               end
               if (ckp_r) begin
                  st_r  <= i2cs_pkg::ST_TX;
                  cnt_r <= i2cs_pkg::CNT_ZERO;
               end
            end
            i2cs_pkg::ST_TX: begin
               if (scl_fall) begin
                  sr_r  <= {sr_r[6:0], 1'b0};
                  cnt_r <= cnt_r + i2cs_pkg::CNT_ONE;
                  if (tx_done) begin
                     st_r <= i2cs_pkg::ST_TXACK;
                  end
               end
            end
            i2cs_pkg::ST_TXACK: begin
               if (scl_rise) begin
                  mack_r <= !sda_lvl_r;
               end else if (scl_fall) begin
                  st_r <= mack_r ? i2cs_pkg::ST_TXW : i2cs_pkg::ST_IDLE;
               end
            end
            default: begin
               st_r <= st_r;
            end
         endcase
      end
   end

   // software-owned configuration registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         intc_r <= i2cs_pkg::RST_ZERO;
         pie_r  <= i2cs_pkg::RST_ZERO;
         dir_r  <= i2cs_pkg::RST_PORTC_DIR;
         addr_r <= i2cs_pkg::RST_ZERO;
         mode_r <= i2cs_pkg::RST_ZERO[3:0];
         en_r   <= 1'b0;
         smp_r  <= 1'b0;
         cke_r  <= 1'b0;
      end else if (reg_wr) begin
         if (reg_addr == i2cs_pkg::OFS_INT_CTRL) begin
            intc_r <= reg_wdata;
         end else if (reg_addr == i2cs_pkg::OFS_IRQ_EN) begin
            pie_r <= reg_wdata;
         end else if (reg_addr == i2cs_pkg::OFS_PORTC_DIR) begin
            dir_r <= reg_wdata;
         end else if (reg_addr == i2cs_pkg::OFS_SLV_ADDR) begin
            addr_r <= reg_wdata;
         end else if (reg_addr == i2cs_pkg::OFS_SER_CTRL) begin
            mode_r <= reg_wdata[3:0];
            en_r   <= reg_wdata[i2cs_pkg::CTRL_EN];
         end else if (reg_addr == i2cs_pkg::OFS_SER_STAT) begin
            smp_r <= reg_wdata[i2cs_pkg::STAT_SMP];
            cke_r <= reg_wdata[i2cs_pkg::STAT_CKE];
         end
      end
   end

   // receive/transmit buffer; a busy buffer keeps its old byte
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         buf_r <= i2cs_pkg::RST_ZERO;
      end else if (take) begin
         buf_r <= sr_r;
      end else if (wr_buf && (st_r != i2cs_pkg::ST_TX)) begin
         buf_r <= reg_wdata;
      end
   end

   // flags that hardware sets and software clears; a set always wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_r <= i2cs_pkg::RST_ZERO;
         ov_r    <= 1'b0;
         wcol_r  <= 1'b0;
         ua_r    <= 1'b0;
         bf_r    <= 1'b0;
      end else begin
         if (reg_wr && (reg_addr == i2cs_pkg::OFS_IRQ_FLAGS)) begin
            flags_r <= reg_wdata;
         end
         if (ack_fall || txack_fall || (sp_mode && (start_ev || stop_ev))) begin
            flags_r[i2cs_pkg::IRQF_SER] <= 1'b1;
         end
         if (reg_wr && (reg_addr == i2cs_pkg::OFS_SER_CTRL)) begin
            ov_r   <= reg_wdata[i2cs_pkg::CTRL_OVF];
            wcol_r <= reg_wdata[i2cs_pkg::CTRL_WCOL];
         end
         if (nak_hit && bf_r) begin
            ov_r <= 1'b1;
         end
         if (wr_buf && (st_r == i2cs_pkg::ST_TX)) begin
            wcol_r <= 1'b1;
         end
         if (wr_addr) begin
            ua_r <= 1'b0;
         end
         if (ack_fall && ua_pend_r) begin
            ua_r <= 1'b1;
         end
         if (rd_buf || tx_done || !slave_on || (txack_fall && !mack_r)) begin
            bf_r <= 1'b0;
         end
         if (take || (wr_buf && (st_r == i2cs_pkg::ST_TXW))) begin
            bf_r <= 1'b1;
         end
      end
   end

   // clock release, direction, data/address and start/stop status
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ckp_r <= 1'b0;
         rw_r  <= 1'b0;
         da_r  <= 1'b0;
         s_r   <= 1'b0;
         p_r   <= 1'b0;
      end else begin
         if (reg_wr && (reg_addr == i2cs_pkg::OFS_SER_CTRL)) begin
            ckp_r <= reg_wdata[i2cs_pkg::CTRL_CKREL];
         end else if ((ack_fall && tx_next_r && ack_r) || (txack_fall && mack_r)) begin
            ckp_r <= 1'b0;
         end
         if (take && is_addr_r && !ten_lo_r) begin
            rw_r <= sr_r[i2cs_pkg::RW_BIT];
         end else if ((txack_fall && !mack_r) || !slave_on) begin
            rw_r <= 1'b0;
         end
         if (take) begin
            da_r <= !is_addr_r;
         end else if (tx_done) begin
            da_r <= 1'b1;
         end else if ((txack_fall && !mack_r) || !slave_on) begin
            da_r <= 1'b0;
         end
         if (!port_on) begin
            s_r <= 1'b0;
            p_r <= 1'b0;
         end else if (start_ev) begin
            s_r <= 1'b1;
            p_r <= 1'b0;
         end else if (stop_ev) begin
            s_r <= 1'b0;
            p_r <= 1'b1;
         end
      end
   end

   // line drive: only ever low, so the pins stay open drain
   assign sda_low  = ((st_r == i2cs_pkg::ST_ACK) && ack_r) ||
                     ((st_r == i2cs_pkg::ST_TX) && !sr_r[7]);
   assign scl_hold = slave_on && (ua_r || ((st_r == i2cs_pkg::ST_TXW) && !ckp_r));

   // registered pin enables and interrupt
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_oe_n_r <= 1'b1;
         sda_oe_n_r <= 1'b1;
         irq_r      <= 1'b0;
      end else begin
         scl_oe_n_r <= dir_r[i2cs_pkg::DIR_SCL] && !scl_hold;
         sda_oe_n_r <= dir_r[i2cs_pkg::DIR_SDA] && !sda_low;
         irq_r      <= intc_r[i2cs_pkg::INTC_GIE] && intc_r[i2cs_pkg::INTC_PEIE] &&
                       pie_r[i2cs_pkg::IRQF_SER] && flags_r[i2cs_pkg::IRQF_SER];
      end
   end

   // read data stands the cycle after the strobe; unmapped reads give zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= i2cs_pkg::RST_ZERO;
      end else if (!reg_rd) begin
         rdata_r <= i2cs_pkg::RST_ZERO;
      end else if (reg_addr == i2cs_pkg::OFS_INT_CTRL) begin
         rdata_r <= intc_r;
      end else if (reg_addr == i2cs_pkg::OFS_IRQ_FLAGS) begin
         rdata_r <= flags_r;
      end else if (reg_addr == i2cs_pkg::OFS_SER_BUF) begin
         rdata_r <= buf_r;
      end else if (reg_addr == i2cs_pkg::OFS_SER_CTRL) begin
         rdata_r <= {wcol_r, ov_r, en_r, ckp_r, mode_r};
      end else if (reg_addr == i2cs_pkg::OFS_PORTC_DIR) begin
         rdata_r <= dir_r;
      end else if (reg_addr == i2cs_pkg::OFS_IRQ_EN) begin
         rdata_r <= pie_r;
      end else if (reg_addr == i2cs_pkg::OFS_SLV_ADDR) begin
         rdata_r <= addr_r;
      end else if (reg_addr == i2cs_pkg::OFS_SER_STAT) begin
         rdata_r <= {smp_r, cke_r, da_r, p_r, s_r, rw_r, ua_r, bf_r};
      end else begin
         rdata_r <= i2cs_pkg::RST_ZERO;
      end
   end

   assign reg_rdata     = rdata_r;
   assign line_out.scl  = 1'b0;
   assign line_out.sda  = 1'b0;
   assign line_oe_n.scl = scl_oe_n_r;
   assign line_oe_n.sda = sda_oe_n_r;
   assign irq           = irq_r;

   // checks on the sequencer and status
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_byte_taken;
      take;
   endsequence
   sequence s_byte_busy;
      nak_hit && bf_r;
   endsequence

   start_sets_s_a: assert property (start_ev |=> s_r && !p_r)
      else $error("start did not set start bit");
   disable_idle_a: assert property (!en_r |=> !s_r && !p_r && st_r == i2cs_pkg::ST_IDLE)
      else $error("disabled port not idle");
   shift_in_bit_a: assert property ((st_r == i2cs_pkg::ST_RX && scl_rise && cnt_r != i2cs_pkg::BYTE_BITS &&
                                      slave_on && !start_ev && !stop_ev) |=> sr_r[0] == $past(sda_lvl_r))
      else $error("bit not shifted on rising clock");
   miss_to_idle_a: assert property ((slave_on && !start_ev && !stop_ev && miss) |=> st_r == i2cs_pkg::ST_IDLE)
      else $error("address miss kept slave busy");
   accept_load_a: assert property (s_byte_taken |=> bf_r && buf_r == $past(sr_r)
                                   ##1 (!line_oe_n.sda || st_r != i2cs_pkg::ST_ACK))
      else $error("accepted byte not loaded or acknowledged");
   busy_no_load_a: assert property (nak_hit |=> buf_r == $past(buf_r) && !ack_r)
      else $error("busy buffer overwritten");
   ovf_on_full_a: assert property (s_byte_busy |=> ov_r)
      else $error("overflow not flagged");
   buf_read_a: assert property ((rd_buf && !take && !(wr_buf && st_r == i2cs_pkg::ST_TXW)) |=> !bf_r)
      else $error("buffer read left full set");
   addr_write_a: assert property ((wr_addr && !(ack_fall && ua_pend_r)) |=> !ua_r)
      else $error("address write left update request");
   ninth_flag_a: assert property (ack_fall |=> flags_r[i2cs_pkg::IRQF_SER])
      else $error("ninth falling edge did not flag");
   tx_stretch_a: assert property ((slave_on && st_r == i2cs_pkg::ST_TXW && !ckp_r) |=> !line_oe_n.scl)
      else $error("clock not stretched before transmit");
   tx_shift_a: assert property ((slave_on && !start_ev && !stop_ev && st_r == i2cs_pkg::ST_TX && scl_fall)
                                |=> sr_r == {$past(sr_r[6:0]), 1'b0})
      else $error("transmit byte not shifted");
   tx_nack_end_a: assert property ((slave_on && !start_ev && !stop_ev && txack_fall && !mack_r)
                                   |=> st_r == i2cs_pkg::ST_IDLE && !rw_r)
      else $error("no-acknowledge did not end transmit");
   stop_flag_a: assert property ((sp_mode && stop_ev) |=> flags_r[i2cs_pkg::IRQF_SER])
      else $error("stop did not raise serial flag");
   dir_pull_a: assert property (!dir_r[i2cs_pkg::DIR_SCL] |=> !line_oe_n.scl)
      else $error("direction output did not pull clock low");

endmodule : i2cs_top

`default_nettype wire

/* File: logic/i2cs_pkg.sv */
// Purpose: constants, types and decode helpers for the two-wire slave port
// Assumes: byte-wide register port at the printed offsets, 250 MHz system clock
// Notes on behaviour
// - slave 7/10-bit addressing, general call ignored
// - bus lines are only ever pulled low
// - after START shift eight bits on rising clock
// - compare address on eighth falling clock edge
// - match and room: load buffer, full, acknowledge, flag
// - buffer busy: no load, no acknowledge, still flag
// - byte arriving while full sets overflow
// - buffer read clears full; overflow cleared by firmware
// - ten-bit first byte is 11110 A9 A8 0
// - ten-bit address bytes set update request, stretch clock
// - address match records direction and address byte
// - read match: acknowledge then stretch until release
// - transmit loads on buffer write, shifts on falls
// - master no-acknowledge ends transmit, resets status
// - serial flag on ninth falling edge per byte
// - start/stop bits cleared on disable, else updated
// - firmware master mode flags start and stop, not bytes
// - direction bit output pulls line low
// - busy bus with interrupt enabled: flag at stop
// - mode codes select slave width and start/stop flags
// - clock release low stretches, high lets go
// - data/address bit follows last byte kind
package i2cs_pkg;

   // register offsets
   localparam logic [7:0] OFS_INT_CTRL  = 8'h0b;
   localparam logic [7:0] OFS_IRQ_FLAGS = 8'h0c;
   localparam logic [7:0] OFS_SER_BUF   = 8'h13;
   localparam logic [7:0] OFS_SER_CTRL  = 8'h14;
   localparam logic [7:0] OFS_PORTC_DIR = 8'h87;
   localparam logic [7:0] OFS_IRQ_EN    = 8'h8c;
   localparam logic [7:0] OFS_SLV_ADDR  = 8'h93;
   localparam logic [7:0] OFS_SER_STAT  = 8'h94;

   // reset values
   localparam logic [7:0] RST_ZERO      = 8'h00;
   localparam logic [7:0] RST_PORTC_DIR = 8'hff;

   // field positions
   localparam int unsigned CTRL_WCOL  = 7;
   localparam int unsigned CTRL_OVF   = 6;
   localparam int unsigned CTRL_EN    = 5;
   localparam int unsigned CTRL_CKREL = 4;
   localparam int unsigned STAT_SMP   = 7;
   localparam int unsigned STAT_CKE   = 6;
   localparam int unsigned IRQF_SER   = 3;
   localparam int unsigned INTC_GIE   = 7;
   localparam int unsigned INTC_PEIE  = 6;
   localparam int unsigned DIR_SCL    = 3;
   localparam int unsigned DIR_SDA    = 4;
   localparam int unsigned ADR_MSB    = 7;
   localparam int unsigned ADR_LSB    = 1;
   localparam int unsigned RW_BIT     = 0;
   localparam int unsigned TEN_LSB    = 3;

   // mode codes
   localparam logic [3:0] MODE_SLV7     = 4'h6;
   localparam logic [3:0] MODE_SLV10    = 4'h7;
   localparam logic [3:0] MODE_FW_MSTR  = 4'hb;
   localparam logic [3:0] MODE_SLV7_SP  = 4'he;
   localparam logic [3:0] MODE_SLV10_SP = 4'hf;

   // address patterns and bit counts
   localparam logic [4:0] TEN_PREFIX   = 5'h1e;
   localparam logic [6:0] GEN_CALL     = 7'h00;
   localparam logic [3:0] BYTE_BITS    = 4'h8;
   localparam logic [3:0] LAST_TX_FALL = 4'h7;
   localparam logic [3:0] CNT_ZERO     = 4'h0;
   localparam logic [3:0] CNT_ONE      = 4'h1;

   // slave sequencer states
   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_RX    = 6'h02,
      ST_ACK   = 6'h04,
      ST_TXW   = 6'h08,
      ST_TX    = 6'h10,
      ST_TXACK = 6'h20
   } i2cs_state_e;

   // the two bus lines as one bundle
   typedef struct packed {
      logic scl;
      logic sda;
   } i2cs_line_s;

   // any of the five two-wire modes
   function automatic logic i2cs_mode_ok(input logic [3:0] m);
      return (m == MODE_SLV7) || (m == MODE_SLV10) || (m == MODE_FW_MSTR) ||
             (m == MODE_SLV7_SP) || (m == MODE_SLV10_SP);
   endfunction : i2cs_mode_ok

   // slave logic active
   function automatic logic i2cs_mode_slave(input logic [3:0] m);
      return i2cs_mode_ok(m) && (m != MODE_FW_MSTR);
   endfunction : i2cs_mode_slave

   // ten-bit addressing
   function automatic logic i2cs_mode_ten(input logic [3:0] m);
      return (m == MODE_SLV10) || (m == MODE_SLV10_SP);
   endfunction : i2cs_mode_ten

   // start/stop conditions raise the serial flag
   function automatic logic i2cs_mode_sp(input logic [3:0] m);
      return (m == MODE_FW_MSTR) || (m == MODE_SLV7_SP) || (m == MODE_SLV10_SP);
   endfunction : i2cs_mode_sp

endpackage : i2cs_pkg

/* File: verif/i2cs_bus_master.sv */
// Purpose: far-side bus master that drives clock and data as open drain
// Assumes: 125 ns bus clock period, pull-ups on both lines
// Notes: a 1 from the model releases the line; it never stretches back
`timescale 1ns/10ps
`default_nettype none
module i2cs_bus_master (
   // open-drain drive, 0 pulls low
   output logic      scl_m,
   output logic      sda_m,
   // resolved data wire
   input  wire logic sda
);
   // data line as seen in each clock high, msb first
   logic [7:0] rx_m;
   initial begin
      scl_m = 1'b1;
      sda_m = 1'b1;
   end
   // start only from an idle or stopped bus
   task automatic start();
      #31 sda_m = 1'b0;
      #62 scl_m = 1'b0;
   endtask : start
   // stop: data rises while clock is high
   task automatic stop();
      #31 sda_m = 1'b0;
      #31 scl_m = 1'b1;
      #62 sda_m = 1'b1;
      #62;
   endtask : stop
   // msb first, then release data and sample the acknowledge
   task automatic xfer(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         #32 sda_m = b[i];
         #31 scl_m = 1'b1;
         #31 rx_m[i] = sda;
         #31 scl_m = 1'b0;
      end
      #32 sda_m = 1'b1;
      #31 scl_m = 1'b1;
      #31 ack = sda;
      #31 scl_m = 1'b0;
      #31;
   endtask : xfer
endmodule : i2cs_bus_master
`default_nettype wire

/* File: verif/i2c_slave_with_fw_master_support_test.sv */
// Purpose: self-checking bench for the two-wire slave port
// Assumes: 250 MHz clock, bus model at 125 ns per bit
// Notes: expectations follow the status layout, plus the irq, ack and line outputs
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin fails++; $display("[ERR] %s exp %h got %h", nm, e, s); end end
module i2c_slave_with_fw_master_support_test;
   logic                 clk, rst_n, reg_wr, reg_rd, scl_m, sda_m, irq, ack;
   logic [7:0]           reg_addr, reg_wdata, reg_rdata, adr, dat;
   int                   fails, n_compared;
   i2cs_pkg::i2cs_line_s line_in, line_out, line_oe_n;
   // wired and: low if anyone pulls
   assign line_in = {scl_m & line_oe_n.scl, sda_m & line_oe_n.sda};
   i2cs_top DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_in(line_in), .line_out(line_out), .line_oe_n(line_oe_n), .irq(irq));
   i2cs_bus_master m (.scl_m(scl_m), .sda_m(sda_m), .sda(line_in.sda));
   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task automatic chk(input logic [7:0] a, input logic [7:0] msk, input logic [7:0] e, input string nm);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 `CHK(nm, e, reg_rdata & msk)
   endtask : chk
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : complete_run
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // a run is about fifteen microseconds
   initial begin
      #200000;
      fails++;
      complete_run();
   end
   initial begin
      {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      void'($urandom(21));
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      chk(8'h14, 8'hff, 8'h00, "control");
      chk(8'h87, 8'hff, 8'hff, "direction");
      chk(8'h94, 8'hff, 8'h00, "status");
      wr(8'h55, 8'h5a);
      chk(8'h55, 8'hff, 8'h00, "unmapped");
      `CHK("line drive", 2'b00, line_out)
      $display("reset test done");
      adr = 8'(($urandom % 127) + 1) << 1;
      dat = 8'($urandom);
      wr(8'h93, adr);
      wr(8'h0b, 8'hc0);
      wr(8'h8c, 8'h08);
      wr(8'h14, 8'h26);
      m.start();
      chk(8'h94, 8'h18, 8'h08, "start seen");
      m.xfer(adr, ack);
      `CHK("addr ack", 1'b0, ack)
      `CHK("irq", 1'b1, irq)
      chk(8'h94, 8'hff, 8'h09, "status addr");
      chk(8'h13, 8'hff, adr, "buffer addr");
      chk(8'h94, 8'h01, 8'h00, "full cleared");
      wr(8'h0c, 8'h00);
      m.xfer(dat, ack);
      `CHK("data ack", 1'b0, ack)
      chk(8'h94, 8'hff, 8'h29, "status data");
      m.xfer(~dat, ack);
      `CHK("busy ack", 1'b1, ack)
      chk(8'h14, 8'h40, 8'h40, "overflow");
      chk(8'h13, 8'hff, dat, "buffer kept");
      m.stop();
      chk(8'h94, 8'h18, 8'h10, "stop seen");
      $display("receive test done");
      wr(8'h14, 8'h26);
      for (int i = 0; i < 2; i++) begin
         if (i == 1) wr(8'h93, 8'h00);
         m.start();
         m.xfer(i ? 8'h00 : adr ^ 8'h02, ack);
         `CHK("foreign ack", 1'b1, ack)
         m.stop();
      end
      $display("reject test done");
      wr(8'h14, 8'h06);
      chk(8'h94, 8'h18, 8'h00, "disabled");
      wr(8'h93, adr);
      m.start();
      m.xfer(adr, ack);
      `CHK("disabled ack", 1'b1, ack)
      m.stop();
      $display("disable test done");
      // read address, one byte out, master ends it with no-acknowledge
      wr(8'h14, 8'h2e);
      wr(8'h0c, 8'h00);
      m.start();
      `CHK("start irq", 1'b1, irq)
      m.xfer(adr | 8'h01, ack);
      `CHK("read ack", 1'b0, ack)
      `CHK("read stretch", 1'b0, line_oe_n.scl)
      chk(8'h94, 8'h25, 8'h05, "read status");
      wr(8'h13, dat);
      wr(8'h14, 8'h3e);
      m.xfer(8'hff, ack);
      `CHK("tx byte", dat, m.rx_m)
      chk(8'h94, 8'h25, 8'h00, "nack status");
      wr(8'h0c, 8'h00);
      m.stop();
      `CHK("stop irq", 1'b1, irq)
      $display("transmit test done");
      // ten-bit write: firmware swaps the address bytes as they match
      wr(8'h14, 8'h27);
      wr(8'h93, 8'hf2);
      m.start();
      m.xfer(8'hf2, ack);
      `CHK("ten high ack", 1'b0, ack)
      `CHK("ten hold", 1'b0, line_oe_n.scl)
      chk(8'h13, 8'hff, 8'hf2, "ten high byte");
      wr(8'h93, dat);
      chk(8'h94, 8'h03, 8'h00, "ten update done");
      m.xfer(dat, ack);
      `CHK("ten low ack", 1'b0, ack)
      chk(8'h94, 8'h23, 8'h03, "ten low status");
      wr(8'h93, 8'hf2);
      chk(8'h13, 8'hff, dat, "ten low byte");
      m.xfer(~dat, ack);
      `CHK("ten data ack", 1'b0, ack)
      m.stop();
      $display("ten-bit test done");
      // firmware master with slave idle: lines moved by direction bits
      wr(8'h14, 8'h2b);
      wr(8'h0c, 8'h00);
      m.start();
      `CHK("fw start irq", 1'b1, irq)
      wr(8'h87, 8'he7);
      @(posedge clk);
      #1 `CHK("fw pull", 2'b00, line_oe_n)
      wr(8'h87, 8'hf7);
      @(posedge clk);
      #1 `CHK("fw release", 2'b01, line_oe_n)
      `CHK("fw lost", 1'b0, line_in.sda)
      wr(8'h87, 8'hff);
      wr(8'h0c, 8'h00);
      m.stop();
      `CHK("fw stop irq", 1'b1, irq)
      $display("master test done");
      complete_run();
   end
endmodule : i2c_slave_with_fw_master_support_test
`default_nettype wire
